// File: rtl/cia_port.v
// indirect configuration access port: target-select and data window
// assumes i/o requests and downstream completions come from logic on
// clock_i; every request waits for its ack before the next one
`timescale 1ns/1ns
`default_nettype none
`include "cia_regs.vh"

module cia_port (
    input  wire        clock_i,
    input  wire        rst_n_i,
    // processor i/o side
    input  wire        io_req_i,
    input  wire        io_wr_i,
    input  wire [15:0] io_addr_i,
    input  wire [3:0]  io_be_i,
    input  wire [31:0] io_wdata_i,
    output wire        io_ack_o,
    output wire [31:0] io_rdata_o,
    output wire        io_busy_o,
    // configuration request toward the serial link
    output wire        cfg_req_o,
    output wire        cfg_wr_o,
    output wire [7:0]  cfg_bus_o,
    output wire [7:0]  cfg_hdr6_o,
    output wire [7:0]  cfg_hdr7_o,
    output wire [3:0]  cfg_be_o,
    output wire [31:0] cfg_wdata_o,
    input  wire        cfg_done_i,
    input  wire [31:0] cfg_rdata_i,
    // ordinary i/o cycle forwarded downstream
    output wire        pass_req_o,
    output wire        pass_wr_o,
    output wire [15:0] pass_addr_o,
    output wire [3:0]  pass_be_o,
    output wire [31:0] pass_wdata_o,
    input  wire        pass_done_i,
    input  wire [31:0] pass_rdata_i
);

    ////////////////////////////////////////////////////////////////////////
    // states, one-hot
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_CFG  = 3'h2;
    localparam [2:0] ST_PASS = 3'h4;

    reg  [2:0]  state_reg;
    reg  [31:0] sel_reg;
    reg  [31:0] win_reg;
    reg         ack_reg;
    // own flop, so busy is not a gate behind the state bits
    reg         busy_reg;
    reg  [31:0] rdata_reg;
    reg         cfg_req_reg;
    reg         cfg_wr_reg;
    reg  [7:0]  cfg_bus_reg;
    reg  [7:0]  cfg_hdr6_reg;
    reg  [7:0]  cfg_hdr7_reg;
    reg  [3:0]  cfg_be_reg;
    reg  [31:0] cfg_wdata_reg;
    reg         pass_req_reg;
    reg         pass_wr_reg;
    reg  [15:0] pass_addr_reg;
    reg  [3:0]  pass_be_reg;
    reg  [31:0] pass_wdata_reg;

    wire [7:0]  hdr_bus;
    wire [7:0]  hdr_byte6;
    wire [7:0]  hdr_byte7;
    wire [31:0] win_merge;

    ////////////////////////////////////////////////////////////////////////
    // decode of the incoming i/o request
    wire sel_hit  = (io_addr_i == `CIA_SEL_ADDR);
    wire win_hit  = (io_addr_i == `CIA_WIN_ADDR);
    wire full_dw  = (io_be_i == `CIA_BE_ALL);
    wire sel_take = sel_hit & full_dw;
    wire cfg_on   = sel_reg[`CIA_EN_BIT];
    wire cfg_go   = win_hit & cfg_on;

    // header fields straight from the current target select
    cia_hdr_pack u_hdr (
        .sel_i   (sel_reg),
        .bus_o   (hdr_bus),
        .byte6_o (hdr_byte6),
        .byte7_o (hdr_byte7)
    );

    ////////////////////////////////////////////////////////////////////////
    // byte-wise merge of a window write; unwritten lanes keep old data
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
            assign win_merge[gi*8 +: 8] = cfg_be_reg[gi] ? cfg_wdata_reg[gi*8 +: 8]
                                                          : win_reg[gi*8 +: 8];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // main sequencer; requests arriving while busy are ignored
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg      <= ST_IDLE;
            sel_reg        <= `CIA_SEL_RESET;
            win_reg        <= `CIA_WIN_RESET;
            ack_reg        <= 1'b0;
            busy_reg       <= 1'b0;
            rdata_reg      <= `CIA_WIN_RESET;
            cfg_req_reg    <= 1'b0;
            cfg_wr_reg     <= 1'b0;
            cfg_bus_reg    <= 8'h00;
            cfg_hdr6_reg   <= 8'h00;
            cfg_hdr7_reg   <= 8'h00;
            cfg_be_reg     <= 4'h0;
            cfg_wdata_reg  <= 32'h00000000;
            pass_req_reg   <= 1'b0;
            pass_wr_reg    <= 1'b0;
            pass_addr_reg  <= 16'h0000;
            pass_be_reg    <= 4'h0;
            pass_wdata_reg <= 32'h00000000;
        end else begin
            // strobes are single-cycle pulses
            ack_reg      <= 1'b0;
            cfg_req_reg  <= 1'b0;
            pass_req_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (io_req_i) begin
                        if (sel_take) begin
                            // select handled locally, answered next cycle
                            if (io_wr_i) begin
                                sel_reg <= io_wdata_i & `CIA_SEL_WMASK;
                            end
                            rdata_reg <= sel_reg;
                            ack_reg   <= 1'b1;
                        end else if (cfg_go) begin
                            // fields frozen at launch, so a later select
                            // write cannot tear an open request
                            cfg_req_reg   <= 1'b1;
                            cfg_wr_reg    <= io_wr_i;
                            cfg_bus_reg   <= hdr_bus;
                            cfg_hdr6_reg  <= hdr_byte6;
                            cfg_hdr7_reg  <= hdr_byte7;
                            cfg_be_reg    <= io_be_i;
                            cfg_wdata_reg <= io_wdata_i;
                            busy_reg      <= 1'b1;
                            state_reg     <= ST_CFG;
                        end else begin
                            // partial select, disabled window, other ports
                            pass_req_reg   <= 1'b1;
                            pass_wr_reg    <= io_wr_i;
                            pass_addr_reg  <= io_addr_i;
                            pass_be_reg    <= io_be_i;
                            pass_wdata_reg <= io_wdata_i;
                            busy_reg       <= 1'b1;
                            state_reg      <= ST_PASS;
                        end
                    end
                end
                ST_CFG: begin
                    if (cfg_done_i) begin
                        if (cfg_wr_reg) begin
                            win_reg   <= win_merge;
                            rdata_reg <= win_merge;
                        end else begin
                            // no masking: reserved space may read nonzero
                            win_reg   <= cfg_rdata_i;
                            rdata_reg <= cfg_rdata_i;
                        end
                        ack_reg   <= 1'b1;
                        busy_reg  <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_PASS: begin
                    if (pass_done_i) begin
                        rdata_reg <= pass_wr_reg ? pass_wdata_reg : pass_rdata_i;
                        ack_reg   <= 1'b1;
                        busy_reg  <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    busy_reg  <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops
    assign io_ack_o     = ack_reg;
    assign io_rdata_o   = rdata_reg;
    assign io_busy_o    = busy_reg;
    assign cfg_req_o    = cfg_req_reg;
    assign cfg_wr_o     = cfg_wr_reg;
    assign cfg_bus_o    = cfg_bus_reg;
    assign cfg_hdr6_o   = cfg_hdr6_reg;
    assign cfg_hdr7_o   = cfg_hdr7_reg;
    assign cfg_be_o     = cfg_be_reg;
    assign cfg_wdata_o  = cfg_wdata_reg;
    assign pass_req_o   = pass_req_reg;
    assign pass_wr_o    = pass_wr_reg;
    assign pass_addr_o  = pass_addr_reg;
    assign pass_be_o    = pass_be_reg;
    assign pass_wdata_o = pass_wdata_reg;

endmodule // cia_port

`default_nettype wire

// File: pkg/cia_regs.vh
// constants for the indirect configuration access port
// assumes a 16-bit processor i/o address and 32-bit data path
`ifndef CIA_REGS_VH
`define CIA_REGS_VH

// processor i/o addresses of the two ports
`define CIA_SEL_ADDR     16'h0CF8
`define CIA_WIN_ADDR     16'h0CFC

// reset values
`define CIA_SEL_RESET    32'h00000000
`define CIA_WIN_RESET    32'h00000000

// writable bits of the target-select register; 30:24 and 1:0 read zero
`define CIA_SEL_WMASK    32'h80FFFFFC

// full doubleword byte enables
`define CIA_BE_ALL       4'hF

// field positions inside the target-select register
`define CIA_EN_BIT       31
`define CIA_BUS_HI       23
`define CIA_BUS_LO       16
`define CIA_DEV_HI       15
`define CIA_DEV_LO       11
`define CIA_FN_HI        10
`define CIA_FN_LO        8
`define CIA_REG_HI       7
`define CIA_REG_LO       2

// low bits of header byte seven below the register number
`define CIA_HDR7_PAD     2'h0

`endif

// File: rtl/cia_hdr_pack.v
// request header packing for outgoing configuration requests
// assumes a target-select word laid out as in cia_regs.vh; pure logic
`timescale 1ns/1ns
`default_nettype none
`include "cia_regs.vh"

module cia_hdr_pack (
    input  wire [31:0] sel_i,
    output wire [7:0]  bus_o,
    output wire [7:0]  byte6_o,
    output wire [7:0]  byte7_o
);

    // bus number goes out whole
    assign bus_o   = sel_i[`CIA_BUS_HI:`CIA_BUS_LO];
    // byte six: device in 7:3, function in 2:0
    assign byte6_o = {sel_i[`CIA_DEV_HI:`CIA_DEV_LO], sel_i[`CIA_FN_HI:`CIA_FN_LO]};
    // byte seven: register number in 7:2
    assign byte7_o = {sel_i[`CIA_REG_HI:`CIA_REG_LO], `CIA_HDR7_PAD};

endmodule // cia_hdr_pack

`default_nettype wire

// File: sim/cia_far_model.sv
// far-side model: link logic and downstream i/o bus answering launches
// assumes one launch at a time; delay and read data set by the bench
`timescale 1ns/1ns
`default_nettype none
module cia_far_model (
    input  wire        clock_i,
    input  wire        cfg_req_i,
    input  wire        pass_req_i,
    input  wire [3:0]  dly_i,
    input  wire [31:0] rv_i,
    output reg         cdone_o,
    output reg         pdone_o,
    output wire [31:0] rdata_o
);
    reg k;
    initial {cdone_o, pdone_o} = 2'h0;
    // data lines show the inverse outside the done pulse, never a stale value
    assign rdata_o = (cdone_o || pdone_o) ? rv_i : ~rv_i;
    // answer each launch after dly_i cycles with a one-cycle done
    always begin
        @(posedge clock_i);
        if (cfg_req_i || pass_req_i) begin
            k = cfg_req_i;
            repeat (dly_i) @(posedge clock_i);
            #1 {cdone_o, pdone_o} = {k, !k};
            @(posedge clock_i);
            #1 {cdone_o, pdone_o} = 2'h0;
        end
    end
endmodule // cia_far_model
`default_nettype wire

// File: sim/cia_port_monitor.sv
// checker for cia_port, bound to it, watching its ports only
// assumes one clock and the constants of cia_regs.vh
`timescale 1ns/1ns
`default_nettype none
`include "cia_regs.vh"
module cia_port_monitor (
    input wire        clock_i, rst_n_i, io_req_i, io_wr_i, io_ack_o, io_busy_o,
    input wire        cfg_req_o, pass_req_o, cfg_done_i, pass_done_i,
    input wire [15:0] io_addr_i,
    input wire [3:0]  io_be_i,
    input wire [31:0] io_wdata_i, io_rdata_o,
    input wire [7:0]  cfg_bus_o, cfg_hdr6_o, cfg_hdr7_o
);
    reg  [31:0] sel_reg;
    wire        tk = io_req_i && !io_busy_o;
    wire        sd = tk && io_addr_i == `CIA_SEL_ADDR && io_be_i == `CIA_BE_ALL;
    wire        wn = tk && io_addr_i == `CIA_WIN_ADDR;
    // shadow select, so launches can be judged without looking inside
    always @(posedge clock_i or negedge rst_n_i)
        if (!rst_n_i) sel_reg <= `CIA_SEL_RESET;
        else if (sd && io_wr_i) sel_reg <= io_wdata_i & `CIA_SEL_WMASK;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    a_sel_ack: assert property (sd |=> io_ack_o && !io_busy_o && !cfg_req_o && !pass_req_o)
        else $error("select access not answered next cycle");
    a_sel_data: assert property (sd |=> io_rdata_o == $past(sel_reg))
        else $error("select read data wrong");
    a_en_cfg: assert property (wn && sel_reg[31] |=> cfg_req_o && !pass_req_o)
        else $error("enabled window access made no config launch");
    a_dis_pass: assert property (wn && !sel_reg[31] |=> pass_req_o && !cfg_req_o)
        else $error("disabled window access not forwarded");
    a_part_pass: assert property (tk && io_addr_i == `CIA_SEL_ADDR && io_be_i != 4'hF
        |=> pass_req_o && !cfg_req_o)
        else $error("partial select access not forwarded");
    a_hdr_reg: assert property (cfg_req_o |-> cfg_hdr7_o == {sel_reg[7:2], 2'h0})
        else $error("header byte seven wrong");
    a_hdr_tgt: assert property (cfg_req_o |-> {cfg_bus_o, cfg_hdr6_o} == sel_reg[23:8])
        else $error("target fields wrong");
    a_done_ack: assert property (io_busy_o && (cfg_done_i || pass_done_i)
        |=> io_ack_o && !io_busy_o)
        else $error("completion not answered next cycle");
endmodule // cia_port_monitor
bind cia_port cia_port_monitor u_mon (.clock_i, .rst_n_i, .io_req_i, .io_wr_i, .io_ack_o,
    .io_busy_o, .cfg_req_o, .pass_req_o, .cfg_done_i, .pass_done_i, .io_addr_i, .io_be_i,
    .io_wdata_i, .io_rdata_o, .cfg_bus_o, .cfg_hdr6_o, .cfg_hdr7_o);
`default_nettype wire

// File: sim/cia_port_bench.sv
// self-checking bench for cia_port with far-side model and checker
// assumes cia_regs.vh on the include path
`timescale 1ns/1ns
`default_nettype none
`include "cia_regs.vh"
module cia_port_bench;
    reg         clock_i = 0, rst_n_i = 0, io_req_i = 0, io_wr_i = 0;
    reg  [15:0] io_addr_i = 16'h0000;
    reg  [3:0]  io_be_i = 4'h0, dly = 4'h0;
    reg  [31:0] io_wdata_i = 32'h0, rv = 32'h0, sel = 32'h0, win = 32'h0, e, d;
    wire        io_ack_o, io_busy_o, cfg_req_o, pass_req_o, cd, pd, cfg_wr_o, pass_wr_o;
    wire [31:0] io_rdata_o, rd, cfg_wdata_o, pass_wdata_o;
    wire [15:0] pass_addr_o;
    wire [7:0]  cfg_bus_o, cfg_hdr6_o, cfg_hdr7_o;
    wire [3:0]  cfg_be_o, pass_be_o;
    integer     seed = 61764, fails = 0, num_checks = 0, cyc = 0, cc = 0, pc = 0, i;
    cia_port u_dut (.clock_i, .rst_n_i, .io_req_i, .io_wr_i, .io_addr_i, .io_be_i, .io_wdata_i,
        .io_ack_o, .io_rdata_o, .io_busy_o, .cfg_req_o, .cfg_wr_o, .cfg_bus_o, .cfg_hdr6_o,
        .cfg_hdr7_o, .cfg_be_o, .cfg_wdata_o, .cfg_done_i(cd), .cfg_rdata_i(rd), .pass_req_o,
        .pass_wr_o, .pass_addr_o, .pass_be_o, .pass_wdata_o, .pass_done_i(pd),
        .pass_rdata_i(rd));
    cia_far_model u_far (.clock_i, .cfg_req_i(cfg_req_o), .pass_req_i(pass_req_o), .dly_i(dly),
        .rv_i(rv), .cdone_o(cd), .pdone_o(pd), .rdata_o(rd));
    always #2 clock_i = !clock_i;
    // count launches; the cycle ceiling cuts a hang short
    always @(posedge clock_i) begin
        if (rst_n_i) {cc, pc} = {cc + cfg_req_o, pc + pass_req_o};
        cyc = cyc + 1;
        if (cyc == 3000) begin fails = fails + 1; complete_run; end
    end
    task cmp(input [63:0] g, input [63:0] x);
        begin
            num_checks = num_checks + 1;
            if (g !== x) begin
                fails = fails + 1;
                $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
            end
        end
    endtask
    // one i/o cycle; reference prediction made beside it, compared at ack
    task acc(input w, input [15:0] a, input [3:0] b, input [31:0] dv);
        integer t, c0, p0, k;
        begin
            {c0, p0} = {cc, pc};
            k = (a == `CIA_SEL_ADDR && b == 4'hF) ? 0 : (a == `CIA_WIN_ADDR && sel[31]) ? 1 : 2;
            rv = $random(seed);
            dly = {$random(seed)} % 4;
            @(posedge clock_i);
            #1 {io_req_i, io_wr_i, io_addr_i, io_be_i, io_wdata_i} = {1'b1, w, a, b, dv};
            @(posedge clock_i);
            #1 io_req_i = 0;
            for (t = 0; t < 40 && io_ack_o !== 1'b1; t = t + 1) @(posedge clock_i) #1;
            case (k)
                0: begin e = sel; if (w) sel = dv & `CIA_SEL_WMASK; end
                1: begin
                    for (t = 0; t < 4; t = t + 1)
                        if (!w || b[t]) win[8*t+:8] = w ? dv[8*t+:8] : rv[8*t+:8];
                    e = win;
                end
                default: e = w ? dv : rv;
            endcase
            cmp(io_ack_o, 1);
            cmp(io_rdata_o, e);
            // launch fields are held until the next launch, so still readable at ack
            if (k == 1) begin
                cmp({cfg_wr_o, cfg_be_o, cfg_wdata_o}, {w, b, dv});
                cmp({cfg_bus_o, cfg_hdr6_o, cfg_hdr7_o}, {sel[23:2], 2'h0});
            end
            if (k == 2) cmp({pass_wr_o, pass_addr_o, pass_be_o, pass_wdata_o}, {w, a, b, dv});
            cmp(cc - c0, k == 1);
            cmp(pc - p0, k == 2);
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", num_checks, fails);
            if (fails == 0 && num_checks > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    initial begin
        repeat (12) @(posedge clock_i);
        #1 rst_n_i = 1;
        // reset state: select zero, window forwarded
        acc(0, `CIA_SEL_ADDR, 4'hF, 0);
        acc(0, `CIA_WIN_ADDR, 4'hF, 0);
        $display("test 1 done");
        // enable with reserved bits set; byte write exposes zero lanes
        acc(1, `CIA_SEL_ADDR, 4'hF, 32'hFFFFFF90);
        acc(1, `CIA_WIN_ADDR, 4'h1, 32'h5A5A5A5A);
        acc(0, `CIA_SEL_ADDR, 4'hF, 0);
        acc(1, `CIA_SEL_ADDR, 4'h3, 0);
        $display("test 2 done");
        // random mix; register numbers kept to listed offsets only
        for (i = 0; i < 40; i = i + 1) begin
            d = $random(seed);
            d[7:0] = d[8] ? 8'h90 : 8'h40;
            acc(d[9], i % 3 == 0 ? `CIA_SEL_ADDR : i % 3 == 1 ? `CIA_WIN_ADDR : 16'h0080,
                d[10] ? 4'hF : d[14:11], d);
        end
        $display("test 3 done");
        complete_run;
    end
endmodule // cia_port_bench
`default_nettype wire
